// File: design/nv_write_ctrl.sv
// Register interface and write controller for the data nonvolatile byte store
//
// What this block does
// - Write trigger starts a write only after keys 55h then AAh on unlock port.
// - Write trigger ignored while write permission is clear.
// - Hardware clears write permission only on power-on or warm reset.
// - A started write completes even if permission is cleared meanwhile.
// - At write end, trigger clears and write-complete flag sets.
// - Write-complete flag stays set until software or a warm reset clears it.
// - Power-on leaves control bits zero; warm reset flags an interrupted write.
// - Read trigger loads addressed byte next cycle, then clears itself.
// - Abort flag sets on warm reset mid-write, clears on normal completion.
// - 64 bytes, index 0h to 3Fh, each write replaces the whole byte.
// - Unlock port stores nothing; it only detects the key sequence.
`timescale 1ns/1ps
`default_nettype none
module nv_write_ctrl
    import nv_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLES_DF
)(
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       warm_reset_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic [7:0] sfr_wdata_in,
    output logic      [7:0] sfr_rdata_out,
    output logic            write_busy_out,
    output logic            program_done_flag_out
);
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_state_t;
    localparam logic [TIMER_WIDTH-1:0] TIMER_LOAD = TIMER_WIDTH'(WRITE_CYCLES - 1);
    // ==========================================
    // Reset and warm reset synchronisers
    logic [1:0] rst_sync_r;
    logic       rst_n;
    logic       warm_meta_r;
    logic       warm_q_r;

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            warm_meta_r <= 1'b0;
            warm_q_r    <= 1'b0;
        end
        else
        begin
            warm_meta_r <= warm_reset_in;
            warm_q_r    <= warm_meta_r;
        end
    end

    // ==========================================
    // Register port decode
    logic ctl_wr;
    logic key_wr;
    logic data_wr;
    logic idx_wr;
    assign ctl_wr  = sfr_wr_in && (sfr_addr_in == OFS_CONTROL);
    assign key_wr  = sfr_wr_in && (sfr_addr_in == OFS_UNLOCK_KEY);
    assign data_wr = sfr_wr_in && (sfr_addr_in == OFS_BYTE_HOLDING);
    assign idx_wr  = sfr_wr_in && (sfr_addr_in == OFS_LOCATION_IDX);

    // ==========================================
    // Unlock key sequence detector, holds no data
    key_state_t key_state_r;
    logic       start_ok;
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            key_state_r <= KEY_IDLE;
        else if (warm_q_r || (sfr_wr_in && !key_wr))
            key_state_r <= KEY_IDLE;
        else if (key_wr)
        begin
            case (key_state_r)
                KEY_IDLE:      key_state_r <= (sfr_wdata_in == KEY_FIRST) ? KEY_GOT_FIRST
                                                                          : KEY_IDLE;
                KEY_GOT_FIRST: key_state_r <= (sfr_wdata_in == KEY_SECOND) ? KEY_ARMED
                                                                           : KEY_IDLE;
                default:       key_state_r <= KEY_IDLE;
            endcase
        end
    end

    // ==========================================
    // Control register
    logic                   permit_r;
    logic                   wr_trig_r;
    logic                   rd_trig_r;
    logic                   abort_r;
    logic                   done_r;
    logic [TIMER_WIDTH-1:0] timer_r;
    logic                   finish;

    assign start_ok = ctl_wr && sfr_wdata_in[BIT_WRITE_TRIG] && permit_r
                      && (key_state_r == KEY_ARMED) && !wr_trig_r;
    assign finish   = wr_trig_r && (timer_r == '0) && !warm_q_r;

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            permit_r <= RST_FLAG;
        else if (warm_q_r)
            permit_r <= RST_FLAG;
        else if (ctl_wr)
            permit_r <= sfr_wdata_in[BIT_PERMIT];
    end

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_trig_r <= RST_FLAG;
            timer_r   <= '0;
        end
        else if (warm_q_r)
        begin
            wr_trig_r <= RST_FLAG;
            timer_r   <= '0;
        end
        else if (start_ok)
        begin
            wr_trig_r <= 1'b1;
            timer_r   <= TIMER_LOAD;
        end
        else if (finish)
            wr_trig_r <= 1'b0;
        else if (wr_trig_r)
            timer_r <= timer_r - 1'b1;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            rd_trig_r <= RST_FLAG;
        else if (warm_q_r)
            rd_trig_r <= RST_FLAG;
        else
            rd_trig_r <= !rd_trig_r && ctl_wr && sfr_wdata_in[BIT_READ_TRIG];
    end

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            abort_r <= RST_FLAG;
        else if (warm_q_r && wr_trig_r)
            abort_r <= 1'b1;
        else if (finish)
            abort_r <= 1'b0;
        else if (ctl_wr && !warm_q_r)
            abort_r <= sfr_wdata_in[BIT_ABORT];
    end

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            done_r <= RST_FLAG;
        else if (warm_q_r)
            done_r <= RST_FLAG;
        else if (finish)
            done_r <= 1'b1;
        else if (ctl_wr)
            done_r <= sfr_wdata_in[BIT_DONE];
    end

    // ==========================================
    // Byte holding, location index, write latches
    logic [7:0]              hold_r;
    logic [7:0]              idx_r;
    logic [NV_IDX_WIDTH-1:0] lat_idx_r;
    logic [7:0]              lat_data_r;
    logic [7:0]              nv_mem [NV_DEPTH];
    logic [7:0]              rd_byte;

    assign rd_byte = nv_mem[idx_r[NV_IDX_WIDTH-1:0]];

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            hold_r <= RST_BYTE;
        else if (rd_trig_r)
            hold_r <= rd_byte;
        else if (data_wr)
            hold_r <= sfr_wdata_in;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            idx_r <= RST_BYTE;
        else if (idx_wr)
            idx_r <= sfr_wdata_in;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lat_idx_r  <= '0;
            lat_data_r <= RST_BYTE;
        end
        else if (start_ok)
        begin
            lat_idx_r  <= idx_r[NV_IDX_WIDTH-1:0];
            lat_data_r <= hold_r;
        end
    end

    // Whole byte replaced at the end of the timed cycle
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_n && finish)
            nv_mem[lat_idx_r] <= lat_data_r;
    end

    // ==========================================
    // Read data and status outputs
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            sfr_rdata_out <= RST_READ_DATA;
        else
        begin
            case (sfr_addr_in)
                OFS_BYTE_HOLDING: sfr_rdata_out <= hold_r;
                OFS_LOCATION_IDX: sfr_rdata_out <= idx_r;
                OFS_CONTROL:      sfr_rdata_out <= {3'b000, done_r, abort_r, permit_r,
                                                    wr_trig_r, rd_trig_r};
                default:          sfr_rdata_out <= RST_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            write_busy_out        <= 1'b0;
            program_done_flag_out <= 1'b0;
        end
        else
        begin
            write_busy_out        <= wr_trig_r;
            program_done_flag_out <= done_r;
        end
    end

    // ==========================================
    // Assertions
    AST_START_NEEDS_KEYS: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        $rose(wr_trig_r) |-> $past(key_state_r == KEY_ARMED) && $past(ctl_wr))
        else $error("Write started without the unlock keys");
    AST_START_NEEDS_PERMIT: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        $rose(wr_trig_r) |-> $past(permit_r))
        else $error("Write started without permission");
    AST_PERMIT_SW_ONLY: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        $fell(permit_r) |-> $past(ctl_wr) || $past(warm_q_r))
        else $error("Permission cleared by hardware");
    AST_WRITE_CONTINUES: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (wr_trig_r && timer_r != '0 && !warm_q_r) |=> wr_trig_r)
        else $error("Write cycle cut short");
    AST_FINISH_FLAGS: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        finish |=> !wr_trig_r && done_r && !abort_r)
        else $error("Completion did not update the control flags");
    AST_DONE_STICKY: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (done_r && !warm_q_r && !(ctl_wr && !sfr_wdata_in[BIT_DONE])) |=> done_r)
        else $error("Write-complete flag dropped without software");
    AST_READ_LOADS: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (rd_trig_r && !warm_q_r) |=> !rd_trig_r && hold_r == $past(rd_byte))
        else $error("Read trigger did not load the byte");
    AST_ABORT_ON_WARM: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (warm_q_r && wr_trig_r) |=> abort_r && !wr_trig_r)
        else $error("Interrupted write not flagged");
    AST_BYTE_STORED: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        finish |=> nv_mem[$past(lat_idx_r)] == $past(lat_data_r))
        else $error("Byte not stored at write end");
    AST_KEY_READS_ZERO: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (sfr_addr_in == OFS_UNLOCK_KEY) |=> sfr_rdata_out == 8'h00)
        else $error("Unlock port returned data");
    AST_WRITE_LENGTH: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        $rose(wr_trig_r) |-> timer_r == TIMER_LOAD)
        else $error("Write timer loaded with wrong length");

endmodule
`default_nettype wire

// File: shared/nv_pkg.sv
// Constants for the data nonvolatile byte store controller
package nv_pkg;
    // Register offsets on the special function register port
    localparam logic [7:0] OFS_BYTE_HOLDING  = 8'h08;
    localparam logic [7:0] OFS_LOCATION_IDX  = 8'h09;
    localparam logic [7:0] OFS_CONTROL       = 8'h88;
    localparam logic [7:0] OFS_UNLOCK_KEY    = 8'h89;
    // Control register bit positions
    localparam int BIT_READ_TRIG  = 0;
    localparam int BIT_WRITE_TRIG = 1;
    localparam int BIT_PERMIT     = 2;
    localparam int BIT_ABORT      = 3;
    localparam int BIT_DONE       = 4;
    // Unlock keys
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // Storage geometry
    localparam int NV_DEPTH     = 64;
    localparam int NV_IDX_WIDTH = 6;
    // Reset values
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [7:0] RST_READ_DATA  = 8'h00;
    localparam logic [7:0] RST_UNMAPPED   = 8'h00;
    localparam logic       RST_FLAG       = 1'b0;
    // Self-timed write length
    localparam int CLK_PERIOD_NS   = 8;
    localparam int WRITE_TIME_NS   = 20000;
    localparam int WRITE_CYCLES_DF = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_WIDTH     = 16;
endpackage

// File: verification/tb_top.sv
// Self-checking testbench for the nonvolatile byte store write controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import nv_pkg::*;
;
    localparam int WC = 8;
    logic       ref_clk_in;
    logic       rstn_in;
    logic       warm_reset_in;
    logic [7:0] sfr_addr_in;
    logic       sfr_wr_in;
    logic [7:0] sfr_wdata_in;
    logic [7:0] sfr_rdata_out;
    logic       write_busy_out;
    logic       program_done_flag_out;
    int         n_fail;
    int         n_checks;
    int         cycles;
    int         len;

    nv_write_ctrl #(.WRITE_CYCLES(WC)) DUT (
        .ref_clk_in           (ref_clk_in),
        .rstn_in              (rstn_in),
        .warm_reset_in        (warm_reset_in),
        .sfr_addr_in          (sfr_addr_in),
        .sfr_wr_in            (sfr_wr_in),
        .sfr_wdata_in         (sfr_wdata_in),
        .sfr_rdata_out        (sfr_rdata_out),
        .write_busy_out       (write_busy_out),
        .program_done_flag_out(program_done_flag_out)
    );

    initial
    begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    // ==========================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        sfr_wr_in    <= 1'b1;
        sfr_addr_in  <= a;
        sfr_wdata_in <= d;
        @(posedge ref_clk_in);
        sfr_wr_in <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk_in);
        sfr_addr_in <= a;
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk(sfr_rdata_out, exp, what);
    endtask

    // Index, read trigger, then holding register
    task automatic mem_chk(input logic [7:0] idx, input logic [7:0] exp);
        wr(OFS_LOCATION_IDX, idx);
        wr(OFS_CONTROL, 8'h01);
        rd_chk(OFS_BYTE_HOLDING, exp, "stored byte");
    endtask

    task automatic start(input logic [7:0] ctl, input logic [7:0] k1, input logic [7:0] k2,
                         input logic [7:0] trig);
        wr(OFS_CONTROL, ctl);
        wr(OFS_UNLOCK_KEY, k1);
        wr(OFS_UNLOCK_KEY, k2);
        wr(OFS_CONTROL, trig);
    endtask

    task automatic busy_len(output int n);
        n = 0;
        #1;
        for (int i = 0; i < 5; i++)
            if (write_busy_out !== 1'b1)
                @(posedge ref_clk_in) #1;
        while (write_busy_out === 1'b1 && n < 100)
        begin
            n++;
            @(posedge ref_clk_in) #1;
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset;
        chk({7'h00, write_busy_out}, 8'h00, "busy after reset");
        chk({7'h00, program_done_flag_out}, 8'h00, "done after reset");
        rd_chk(OFS_CONTROL, 8'h00, "control after reset");
        rd_chk(OFS_UNLOCK_KEY, 8'h00, "unlock port read");
        rd_chk(8'h20, RST_UNMAPPED, "unmapped read");
    endtask

    task automatic t_refused;
        start(8'h00, KEY_FIRST, KEY_SECOND, 8'h02);
        repeat (4) @(posedge ref_clk_in);
        #1;
        chk({7'h00, write_busy_out}, 8'h00, "trigger without permit");
        rd_chk(OFS_CONTROL, 8'h00, "control without permit");
        start(8'h04, KEY_SECOND, KEY_FIRST, 8'h06);
        repeat (4) @(posedge ref_clk_in);
        #1;
        chk({7'h00, write_busy_out}, 8'h00, "keys reversed");
        rd_chk(OFS_CONTROL, 8'h04, "control keys reversed");
    endtask

    task automatic t_write;
        wr(OFS_LOCATION_IDX, 8'h3F);
        wr(OFS_BYTE_HOLDING, 8'hA5);
        start(8'h04, KEY_FIRST, KEY_SECOND, 8'h06);
        busy_len(len);
        chk(8'(len), 8'(WC), "write length");
        rd_chk(OFS_CONTROL, 8'h14, "control after write");
        wr(OFS_LOCATION_IDX, 8'h00);
        wr(OFS_BYTE_HOLDING, 8'h5A);
        start(8'h04, KEY_FIRST, KEY_SECOND, 8'h06);
        rd_chk(OFS_CONTROL, 8'h06, "trigger during write");
        wr(OFS_CONTROL, 8'h00);
        busy_len(len);
        rd_chk(OFS_CONTROL, 8'h10, "permit dropped mid write");
        repeat (20) @(posedge ref_clk_in);
        #1;
        chk({7'h00, program_done_flag_out}, 8'h01, "done held");
        wr(OFS_CONTROL, 8'h00);
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk({7'h00, program_done_flag_out}, 8'h00, "done cleared");
        mem_chk(8'h3F, 8'hA5);
        mem_chk(8'h00, 8'h5A);
        mem_chk(8'h7F, 8'hA5);
    endtask

    task automatic t_warm;
        wr(OFS_LOCATION_IDX, 8'h00);
        wr(OFS_BYTE_HOLDING, 8'hC3);
        start(8'h04, KEY_FIRST, KEY_SECOND, 8'h06);
        warm_reset_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        warm_reset_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        #1;
        chk({7'h00, write_busy_out}, 8'h00, "busy after warm reset");
        rd_chk(OFS_CONTROL, 8'h08, "abort flag");
        mem_chk(8'h00, 8'h5A);
        wr(OFS_BYTE_HOLDING, 8'h3C);
        start(8'h04, KEY_FIRST, KEY_SECOND, 8'h06);
        busy_len(len);
        rd_chk(OFS_CONTROL, 8'h14, "abort cleared");
        mem_chk(8'h00, 8'h3C);
    endtask

    // ==========================================
    // Hang guard
    always @(posedge ref_clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_fail++;
            results();
        end
    end

    initial
    begin
        n_fail        = 0;
        n_checks      = 0;
        cycles        = 0;
        rstn_in       = 1'b0;
        warm_reset_in = 1'b0;
        sfr_addr_in   = 8'h00;
        sfr_wr_in     = 1'b0;
        sfr_wdata_in  = 8'h00;
        repeat (16) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        #1;
        t_reset();
        t_refused();
        t_write();
        t_warm();
        results();
    end
endmodule
`default_nettype wire
